// ==== hw/mrep_endpoint.sv ====
// Report endpoint of the mouse: report buffer, motion accumulators, button debounce, handshakes.
`timescale 1ns/1ps
module mrep_endpoint (
    input  wire logic                           sys_clk,               // System clock, 40 MHz.
    input  wire logic                           reset_n,               // Asynchronous reset, active low.
    input  wire logic                           usb_reset,             // USB bus reset seen, one-cycle pulse.
    input  wire mrep_pkg::mrep_dev_t            dev_state,             // USB device state.
    input  wire logic                           z_present,             // A scroll wheel is fitted.
    input  wire logic [mrep_pkg::BTN_W-1:0]     btn_pin,               // Raw button pins, high when pressed.
    input  wire logic                           motion_valid,          // Motion step offered.
    input  wire logic [7:0]                     motion_dx,             // Signed X step.
    input  wire logic [7:0]                     motion_dy,             // Signed Y step.
    input  wire logic [7:0]                     motion_dz,             // Signed Z step.
    output logic                                motion_ready,          // Motion step accepted.
    input  wire logic                           report_endpoint_poll,  // IN token on the report endpoint.
    input  wire logic                           report_endpoint_halt_set, // Set-feature halt accepted.
    input  wire logic                           report_endpoint_halt_clr, // Clear-feature halt accepted.
    input  wire logic                           report_sent,           // Host acknowledged the data packet.
    input  wire logic                           idle_rate_wr,          // Set-idle request strobe.
    input  wire logic [7:0]                     idle_rate_in,          // Set-idle rate value.
    output mrep_pkg::mrep_hs_t                  poll_answer,           // Answer to the poll, pulse.
    output logic [mrep_pkg::REP_W-1:0]          report_data,           // Report bytes, button byte lowest.
    output logic [2:0]                          report_len,            // Report length in bytes.
    output logic                                report_endpoint_halted, // Halt flag.
    output logic [7:0]                          idle_rate,             // Current idle rate.
    output logic [mrep_pkg::BTN_W-1:0]          btn_debounced,         // Debounced buttons.
    input  wire logic [15:0]                    ctrl_wlength,          // Requested length of a control read.
    input  wire logic                           ctrl_short_read,       // Request is a status/config/interface read.
    output logic [15:0]                         ctrl_reply_len         // Bytes the control read returns.
);
    import mrep_pkg::*;

    // Motion steps pass through the FIFO; its read side is always ready, so the buffer logic never stalls the sensor.
    mrep_stream_if #(.W(24)) mot_in ();
    mrep_stream_if #(.W(24)) mot_out ();
    assign mot_in.valid  = motion_valid;
    assign mot_in.data   = {motion_dz, motion_dy, motion_dx};
    assign motion_ready  = mot_in.ready;
    assign mot_out.ready = 1'b1;

    mrep_fifo #(.W(24), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .clr     (usb_reset),
        .wr      (mot_in),
        .rd      (mot_out)
    );

    // Three-stage synchroniser, then one stable-time filter with one counter shared by all buttons.
    logic [BTN_W-1:0] s1_reg, s2_reg, s3_reg;
    logic [BTN_W-1:0] deb_reg, deb_next;
    logic [15:0]      dcnt_reg, dcnt_next;
    always_comb begin
        deb_next  = deb_reg;
        dcnt_next = dcnt_reg;
        if (s2_reg != s3_reg || s3_reg == deb_reg) begin
            dcnt_next = 16'h0000;
        end else if (dcnt_reg == 16'(DEB_CYCLES - 1)) begin
            deb_next  = s3_reg;
            dcnt_next = 16'h0000;
        end else begin
            dcnt_next = dcnt_reg + 16'h0001;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg   <= BTN_RST;
            s2_reg   <= BTN_RST;
            s3_reg   <= BTN_RST;
            deb_reg  <= BTN_RST;
            dcnt_reg <= 16'h0000;
        end else begin
            s1_reg   <= btn_pin;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            deb_reg  <= deb_next;
            dcnt_reg <= dcnt_next;
        end
    end
    assign btn_debounced = deb_reg;

    // Report buffer, accumulators and saved button copy.
    logic               full_reg, full_next;
    logic [BTN_W-1:0]   rb_btn_reg, rb_btn_next;
    logic [MOT_W-1:0]   rb_x_reg, rb_x_next, rb_y_reg, rb_y_next;
    logic [7:0]         rb_z_reg, rb_z_next;
    logic [MOT_W-1:0]   acc_x_reg, acc_x_next, acc_y_reg, acc_y_next;
    logic [7:0]         acc_z_reg, acc_z_next;
    logic               acc_any_reg, acc_any_next;
    logic [BTN_W-1:0]   last_btn_reg, last_btn_next;
    logic               halt_reg, halt_next;
    logic [7:0]         idle_reg, idle_next;
    logic               configured, mv, drain;
    logic [MOT_W-1:0]   dx, dy;
    logic [7:0]         dz;

    assign configured = (dev_state == MREP_CONFIGURED);
    assign mv         = mot_out.valid;
    assign dx         = mrep_sext(mot_out.data[7:0]);
    assign dy         = mrep_sext(mot_out.data[15:8]);
    assign dz         = mot_out.data[23:16];
    assign drain      = full_reg && report_sent;

    always_comb begin
        full_next     = full_reg;
        rb_btn_next   = rb_btn_reg;
        rb_x_next     = rb_x_reg;
        rb_y_next     = rb_y_reg;
        rb_z_next     = rb_z_reg;
        acc_x_next    = acc_x_reg;
        acc_y_next    = acc_y_reg;
        acc_z_next    = acc_z_reg;
        acc_any_next  = acc_any_reg;
        last_btn_next = last_btn_reg;
        halt_next     = halt_reg;
        idle_next     = idle_reg;
        if (report_endpoint_halt_set && configured) begin
            halt_next = 1'b1;
        end else if (report_endpoint_halt_clr) begin
            halt_next = 1'b0;
        end
        if (idle_rate_wr) begin
            idle_next = idle_rate_in;
        end
        if (full_reg && !drain) begin
            // Buttons are not tracked as events here; the copy is compared at drain time.
            if (mv) begin
                acc_x_next   = acc_x_reg + dx;
                acc_y_next   = acc_y_reg + dy;
                acc_z_next   = acc_z_reg + dz;
                acc_any_next = 1'b1;
            end
        end else if (drain) begin
            if (acc_any_reg || mv || deb_reg != last_btn_reg) begin
                // The step landing in the drain cycle joins the transfer rather than being lost.
                rb_x_next     = acc_x_reg + (mv ? dx : MOT_RST);
                rb_y_next     = acc_y_reg + (mv ? dy : MOT_RST);
                rb_z_next     = acc_z_reg + (mv ? dz : 8'h00);
                rb_btn_next   = deb_reg;
                last_btn_next = deb_reg;
                full_next     = 1'b1;
            end else begin
                full_next = 1'b0;
            end
            acc_x_next   = MOT_RST;
            acc_y_next   = MOT_RST;
            acc_z_next   = 8'h00;
            acc_any_next = 1'b0;
        end else if (configured && (mv || deb_reg != last_btn_reg)) begin
            rb_x_next     = mv ? dx : MOT_RST;
            rb_y_next     = mv ? dy : MOT_RST;
            rb_z_next     = mv ? dz : 8'h00;
            rb_btn_next   = deb_reg;
            last_btn_next = deb_reg;
            full_next     = 1'b1;
        end
        if (usb_reset) begin
            full_next     = 1'b0;
            rb_btn_next   = BTN_RST;
            rb_x_next     = MOT_RST;
            rb_y_next     = MOT_RST;
            rb_z_next     = 8'h00;
            acc_x_next    = MOT_RST;
            acc_y_next    = MOT_RST;
            acc_z_next    = 8'h00;
            acc_any_next  = 1'b0;
            last_btn_next = BTN_RST;
            halt_next     = 1'b0;
            idle_next     = IDLE_RATE_RST;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            full_reg     <= 1'b0;
            rb_btn_reg   <= BTN_RST;
            rb_x_reg     <= MOT_RST;
            rb_y_reg     <= MOT_RST;
            rb_z_reg     <= 8'h00;
            acc_x_reg    <= MOT_RST;
            acc_y_reg    <= MOT_RST;
            acc_z_reg    <= 8'h00;
            acc_any_reg  <= 1'b0;
            last_btn_reg <= BTN_RST;
            halt_reg     <= 1'b0;
            idle_reg     <= IDLE_RATE_RST;
        end else begin
            full_reg     <= full_next;
            rb_btn_reg   <= rb_btn_next;
            rb_x_reg     <= rb_x_next;
            rb_y_reg     <= rb_y_next;
            rb_z_reg     <= rb_z_next;
            acc_x_reg    <= acc_x_next;
            acc_y_reg    <= acc_y_next;
            acc_z_reg    <= acc_z_next;
            acc_any_reg  <= acc_any_next;
            last_btn_reg <= last_btn_next;
            halt_reg     <= halt_next;
            idle_reg     <= idle_next;
        end
    end

    // Handshake answer is combinational; the packet bytes come straight from the buffer registers.
    always_comb begin
        poll_answer = MREP_HS_NONE;
        if (report_endpoint_poll && configured) begin
            if (halt_reg) begin
                poll_answer = MREP_HS_STALL;
            end else if (full_reg) begin
                poll_answer = MREP_HS_DATA;
            end else begin
                poll_answer = MREP_HS_NAK;
            end
        end
    end
    // Byte order: buttons, X low, X/Y high nibbles, Y low, Z.
    assign report_data = {rb_z_reg, rb_y_reg[7:0], rb_y_reg[11:8], rb_x_reg[11:8],
                          rb_x_reg[7:0], {(8-BTN_W){1'b0}}, rb_btn_reg};
    assign report_len  = z_present ? 3'h5 : 3'h4;
    assign report_endpoint_halted = halt_reg;
    assign idle_rate = idle_reg;
    // A zero-length status, configuration or interface read still returns one byte.
    assign ctrl_reply_len = (ctrl_short_read && ctrl_wlength == 16'h0000) ? 16'h0001 : ctrl_wlength;

    chk_nak_when_empty: assert property (@(posedge sys_clk) disable iff (!reset_n)
        report_endpoint_poll && configured && !halt_reg && !full_reg |-> poll_answer == MREP_HS_NAK)
        else $error("poll without report did not NAK");
    chk_stall_only_halt: assert property (@(posedge sys_clk) disable iff (!reset_n)
        poll_answer == MREP_HS_STALL |-> halt_reg)
        else $error("stall without halt flag");
    chk_no_rep_unconf: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !configured |-> poll_answer != MREP_HS_DATA)
        else $error("report answered while not configured");
    chk_acc_grows: assert property (@(posedge sys_clk) disable iff (!reset_n)
        full_reg && !drain && mv && !usb_reset |=> acc_x_reg == $past(acc_x_reg) + $past(dx))
        else $error("motion lost while buffer full");
    chk_acc_cleared: assert property (@(posedge sys_clk) disable iff (!reset_n)
        drain |=> acc_x_reg == MOT_RST && acc_y_reg == MOT_RST && !acc_any_reg)
        else $error("accumulators not cleared after transfer");
    chk_copy_matches: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(full_reg) |-> rb_btn_reg == last_btn_reg)
        else $error("saved button copy differs from loaded state");
    chk_btn_ignored: assert property (@(posedge sys_clk) disable iff (!reset_n)
        full_reg && !drain && !usb_reset |=> $stable(rb_btn_reg))
        else $error("button changed in full buffer");
    chk_zero_len_one: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_short_read && ctrl_wlength == 16'h0000 |-> ctrl_reply_len == 16'h0001)
        else $error("zero-length read did not return one byte");
    chk_usb_reset_clr: assert property (@(posedge sys_clk) disable iff (!reset_n)
        usb_reset |=> !full_reg && acc_x_reg == MOT_RST && idle_reg == IDLE_RATE_RST && rb_x_reg == MOT_RST)
        else $error("USB reset left state behind");
    cov_data_sent: cover property (@(posedge sys_clk) disable iff (!reset_n) poll_answer == MREP_HS_DATA);
    cov_drain_acc: cover property (@(posedge sys_clk) disable iff (!reset_n) drain && acc_any_reg);
    cov_stall: cover property (@(posedge sys_clk) disable iff (!reset_n) poll_answer == MREP_HS_STALL);
endmodule

// ==== shared/mrep_pkg.sv ====
// Constants and types shared by the mouse report endpoint design.
package mrep_pkg;
    localparam int BTN_W = 3;
    localparam int MOT_W = 12;
    localparam int REP_W = 40;
    localparam int FIFO_DEPTH = 8;
    localparam int DEB_TIME_US = 5;
    localparam int CLK_MHZ = 40;
    localparam int DEB_CYCLES = DEB_TIME_US * CLK_MHZ;
    localparam logic [7:0] IDLE_RATE_RST = 8'h00;
    localparam logic [BTN_W-1:0] BTN_RST = 3'h0;
    localparam logic [MOT_W-1:0] MOT_RST = 12'h000;
    typedef enum logic [1:0] {
        MREP_HS_NONE  = 2'h0,
        MREP_HS_NAK   = 2'h1,
        MREP_HS_DATA  = 2'h3,
        MREP_HS_STALL = 2'h2
    } mrep_hs_t;
    typedef enum logic [1:0] {
        MREP_DEFAULT    = 2'h0,
        MREP_ADDRESSED  = 2'h1,
        MREP_CONFIGURED = 2'h3
    } mrep_dev_t;
    // Sign-extend an 8-bit step to the motion width.
    function automatic logic [MOT_W-1:0] mrep_sext(input logic [7:0] v);
        mrep_sext = {{(MOT_W-8){v[7]}}, v};
    endfunction
endpackage

// ==== shared/mrep_stream_if.sv ====
// Valid/ready stream carrying motion steps between the report logic and its FIFO.
`timescale 1ns/1ps
interface mrep_stream_if #(parameter int W = 32);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== hw/mrep_fifo.sv ====
// Parameterised FIFO with valid/ready on both sides and registered read data.
`timescale 1ns/1ps
module mrep_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 8
) (
    input  wire logic   sys_clk,   // System clock.
    input  wire logic   reset_n,   // Asynchronous reset, active low.
    input  wire logic   clr,       // Synchronous flush on USB reset.
    mrep_stream_if.snk  wr,        // Filling side.
    mrep_stream_if.src  rd         // Draining side.
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW:0]   wp_reg, wp_next, rp_reg, rp_next;
    logic [W-1:0]  out_reg, out_next;
    logic          ov_reg, ov_next;
    logic          full, wr_go, rd_go, load;
    assign full     = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
    assign wr.ready = !full;
    assign wr_go    = wr.valid && !full;
    assign rd.valid = ov_reg;
    assign rd.data  = out_reg;
    assign rd_go    = ov_reg && rd.ready;
    assign load     = (wp_reg != rp_reg) && (!ov_reg || rd_go);
    always_comb begin
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        out_next = out_reg;
        ov_next  = ov_reg;
        if (wr_go) begin
            wp_next = wp_reg + 1'b1;
        end
        if (rd_go) begin
            ov_next = 1'b0;
        end
        if (load) begin
            out_next = mem_reg[rp_reg[AW-1:0]];
            ov_next  = 1'b1;
            rp_next  = rp_reg + 1'b1;
        end
        if (clr) begin
            wp_next = '0;
            rp_next = '0;
            ov_next = 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            out_reg <= '0;
            ov_reg  <= 1'b0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            out_reg <= out_next;
            ov_reg  <= ov_next;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (wr_go) begin
            mem_reg[wp_reg[AW-1:0]] <= wr.data;
        end
    end
endmodule

// ==== sim/mrep_host_model.sv ====
// Behavioural host controller that polls the report endpoint and acknowledges data packets.
`timescale 1ns/1ps
module mrep_host_model (
    input  wire logic               sys_clk,               // System clock.
    input  wire mrep_pkg::mrep_hs_t poll_answer,           // Handshake from the endpoint.
    output logic                    report_endpoint_poll,  // IN token pulse.
    output logic                    report_sent            // Acknowledge of a data packet.
);
    import mrep_pkg::*;
    initial begin
        report_endpoint_poll = 1'b0;
        report_sent          = 1'b0;
    end
    // The answer is combinational, so it is taken mid-cycle while the token is still up.
    task automatic poll_once(output mrep_hs_t ans);
        @(negedge sys_clk);
        report_endpoint_poll = 1'b1;
        #10;
        ans = poll_answer;
        @(negedge sys_clk);
        report_endpoint_poll = 1'b0;
    endtask
    // Only called after a poll that was answered with data.
    task automatic ack();
        @(negedge sys_clk);
        report_sent = 1'b1;
        @(negedge sys_clk);
        report_sent = 1'b0;
    endtask
endmodule

// ==== sim/tb_mouse_report_endpoint.sv ====
// Self-checking testbench of the mouse report endpoint.
`timescale 1ns/1ps
module tb_mouse_report_endpoint;
    import mrep_pkg::*;
    typedef struct packed {
        logic [7:0]  dx;
        logic [7:0]  dy;
        logic [7:0]  dz;
        logic        z;
        logic [39:0] exp;
        logic [2:0]  len;
    } mrep_row_t;
    localparam mrep_row_t ROWS [3] = '{
        '{8'h01, 8'hFF, 8'h02, 1'b1, 40'h02FFF00100, 3'h5},
        '{8'h80, 8'h7F, 8'h00, 1'b0, 40'h007F0F8000, 3'h4},
        '{8'h00, 8'h00, 8'hFF, 1'b1, 40'hFF00000000, 3'h5}};
    logic               sys_clk;
    logic               reset_n;
    logic               usb_reset;
    mrep_dev_t          dev_state;
    logic               z_present;
    logic [BTN_W-1:0]   btn_pin;
    logic               motion_valid;
    logic [7:0]         motion_dx;
    logic [7:0]         motion_dy;
    logic [7:0]         motion_dz;
    logic               motion_ready;
    logic               report_endpoint_poll;
    logic               halt_set;
    logic               halt_clr;
    logic               report_sent;
    logic               idle_rate_wr;
    logic [7:0]         idle_rate_in;
    mrep_hs_t           poll_answer;
    logic [REP_W-1:0]   report_data;
    logic [2:0]         report_len;
    logic               halted;
    logic [7:0]         idle_rate;
    logic [BTN_W-1:0]   btn_debounced;
    logic [15:0]        ctrl_wlength;
    logic               ctrl_short_read;
    logic [15:0]        ctrl_reply_len;
    int                 fail_count;
    int                 checks_done;
    mrep_hs_t           ans;
    mrep_endpoint DUT (.sys_clk(sys_clk), .reset_n(reset_n), .usb_reset(usb_reset), .dev_state(dev_state),
        .z_present(z_present), .btn_pin(btn_pin), .motion_valid(motion_valid), .motion_dx(motion_dx),
        .motion_dy(motion_dy), .motion_dz(motion_dz), .motion_ready(motion_ready),
        .report_endpoint_poll(report_endpoint_poll), .report_endpoint_halt_set(halt_set),
        .report_endpoint_halt_clr(halt_clr), .report_sent(report_sent), .idle_rate_wr(idle_rate_wr),
        .idle_rate_in(idle_rate_in), .poll_answer(poll_answer), .report_data(report_data),
        .report_len(report_len), .report_endpoint_halted(halted), .idle_rate(idle_rate),
        .btn_debounced(btn_debounced), .ctrl_wlength(ctrl_wlength), .ctrl_short_read(ctrl_short_read),
        .ctrl_reply_len(ctrl_reply_len));
    mrep_host_model host (.sys_clk(sys_clk), .poll_answer(poll_answer),
        .report_endpoint_poll(report_endpoint_poll), .report_sent(report_sent));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d of %0d checks", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // The step is held until a rising edge sees ready, then released at the following falling edge.
    task automatic send(input logic [7:0] dx, input logic [7:0] dy, input logic [7:0] dz);
        int n;
        @(negedge sys_clk);
        motion_valid = 1'b1;
        motion_dx = dx;
        motion_dy = dy;
        motion_dz = dz;
        n = 0;
        while (motion_ready !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 100) begin
            fail_count++;
        end
        @(negedge sys_clk);
        motion_valid = 1'b0;
    endtask
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask
    task automatic expect_poll(input mrep_hs_t exp);
        host.poll_once(ans);
        check("poll_answer", 40'(ans), 40'(exp));
    endtask
    initial begin
        #(25 * 20000);
        fail_count++;
        final_report();
    end
    initial begin
        {usb_reset, z_present, btn_pin, motion_valid, motion_dx, motion_dy, motion_dz} = '0;
        {halt_set, halt_clr, idle_rate_wr, idle_rate_in, ctrl_wlength, ctrl_short_read} = '0;
        dev_state = MREP_DEFAULT;
        fail_count = 0;
        checks_done = 0;
        reset_n = 1'b0;
        repeat (16) @(negedge sys_clk);
        reset_n = 1'b1;
        check("idle_rate", 40'(idle_rate), 40'(IDLE_RATE_RST));
        check("report_data", report_data, 40'h0);
        check("poll_answer", 40'(poll_answer), 40'(MREP_HS_NONE));
        check("motion_ready", 40'(motion_ready), 40'h1);
        expect_poll(MREP_HS_NONE);
        dev_state = MREP_ADDRESSED;
        expect_poll(MREP_HS_NONE);
        pulse(halt_set);
        check("halted", 40'(halted), 40'h0);
        idle_rate_in = 8'h7D;
        pulse(idle_rate_wr);
        check("idle_rate", 40'(idle_rate), 40'h7D);
        dev_state = MREP_CONFIGURED;
        expect_poll(MREP_HS_NAK);
        for (int i = 0; i < 3; i++) begin
            z_present = ROWS[i].z;
            send(ROWS[i].dx, ROWS[i].dy, ROWS[i].dz);
            repeat (4) @(negedge sys_clk);
            expect_poll(MREP_HS_DATA);
            check("report_data", report_data, ROWS[i].exp);
            check("report_len", 40'(report_len), 40'(ROWS[i].len));
            host.ack();
            repeat (4) @(negedge sys_clk);
            expect_poll(MREP_HS_NAK);
        end
        pulse(halt_set);
        check("halted", 40'(halted), 40'h1);
        expect_poll(MREP_HS_STALL);
        pulse(halt_clr);
        expect_poll(MREP_HS_NAK);
        ctrl_short_read = 1'b1;
        @(negedge sys_clk);
        check("ctrl_reply_len", 40'(ctrl_reply_len), 40'h1);
        ctrl_wlength = 16'h0008;
        @(negedge sys_clk);
        check("ctrl_reply_len", 40'(ctrl_reply_len), 40'h8);
        ctrl_wlength = 16'h0000;
        ctrl_short_read = 1'b0;
        @(negedge sys_clk);
        check("ctrl_reply_len", 40'(ctrl_reply_len), 40'h0);
        // A first step fills the empty buffer; more motion and a button press then arrive while it holds that report.
        send(8'h01, 8'h00, 8'h00);
        btn_pin = 3'h5;
        repeat (250) @(negedge sys_clk);
        check("btn_debounced", 40'(btn_debounced), 40'h5);
        check("report_data", report_data, 40'h0000000100);
        send(8'h7F, 8'hFE, 8'h00);
        send(8'h7F, 8'h00, 8'h00);
        send(8'h7F, 8'h00, 8'h00);
        repeat (10) @(negedge sys_clk);
        check("report_data", report_data, 40'h0000000100);
        expect_poll(MREP_HS_DATA);
        host.ack();
        repeat (4) @(negedge sys_clk);
        check("report_data", report_data, 40'h00FEF17D05);
        expect_poll(MREP_HS_DATA);
        host.ack();
        repeat (4) @(negedge sys_clk);
        expect_poll(MREP_HS_NAK);
        send(8'h01, 8'h00, 8'h00);
        repeat (4) @(negedge sys_clk);
        check("report_data", report_data, 40'h0000000105);
        btn_pin = 3'h0;
        repeat (250) @(negedge sys_clk);
        check("report_data", report_data, 40'h0000000105);
        send(8'h05, 8'h00, 8'h00);
        repeat (4) @(negedge sys_clk);
        pulse(halt_set);
        pulse(usb_reset);
        repeat (3) @(negedge sys_clk);
        check("halted", 40'(halted), 40'h0);
        check("idle_rate", 40'(idle_rate), 40'(IDLE_RATE_RST));
        check("report_data", report_data, 40'h0);
        expect_poll(MREP_HS_NAK);
        // A button change alone must fill an empty buffer.
        btn_pin = 3'h2;
        repeat (250) @(negedge sys_clk);
        check("report_data", report_data, 40'h0000000002);
        expect_poll(MREP_HS_DATA);
        final_report();
    end
endmodule
